/* File: include/scs_defines.svh */
// Constants for the switching clock and strap configuration block
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// ==================================================
// Timing and frequency limits
`define SCS_CLK_NS 100
`define SCS_REF_KHZ 30000
`define SCS_FMIN_KHZ 200
`define SCS_FMAX_KHZ 1000
`define SCS_NMIN 30
`define SCS_NMAX 150
`define SCS_LOSS_NS 20000 // Longer than the slowest switching period plus drift
`define SCS_LOSS_CYC ((`SCS_LOSS_NS) / (`SCS_CLK_NS))
`define SCS_SETTLE_CYC 4

// ==================================================
// Register byte offsets
`define SCS_OFF_CTRL 8'h00
`define SCS_OFF_FREQ 8'h04
`define SCS_OFF_STAT 8'h08
`define SCS_OFF_FCFG 8'h0c
`define SCS_OFF_LOOP 8'h10
`define SCS_OFF_LIM0 8'h14
`define SCS_OFF_LIM1 8'h18
`define SCS_OFF_STRP 8'h1c

// ==================================================
// Field positions
`define SCS_CTRL_EXT 0
`define SCS_CTRL_SOUT 1
`define SCS_STAT_FAULT 0
`define SCS_STAT_EXTACT 1
`define SCS_STAT_RUN 2
`define SCS_STAT_BUSY 3
`define SCS_STAT_DONE 4
`define SCS_FCFG_RETRY 0
`define SCS_FCFG_DIODE 1

// ==================================================
// Reset and fixed values
`define SCS_RST_KHZ 16'h01f4
`define SCS_RST_DIV 8'h3c
`define SCS_RST_GAIN 16'h0190
`define SCS_LOOP_RESID 8'h4f
`define SCS_LOOP_INTEG 8'h64
`define SCS_OPEN_SYNC 4'h5
`define SCS_OPEN_FAULT_LIMIT_STRAP 4'h1
`define SCS_OPEN_LOOP_GAIN_STRAP 4'h2

`endif

/* File: include/scs_pkg.sv */
// Types for the switching clock and strap configuration block
`default_nettype none

package scs_pkg;
    // Divisor engine states
    typedef enum logic [1:0] {
        SCS_CAPT,
        SCS_IDLE,
        SCS_DIV,
        SCS_PICK
    } scs_state_e;
endpackage : scs_pkg

`default_nettype wire

/* File: hdl/scs_switch_clock.sv */
// Switching clock generator, sync loss monitor and strap decoder
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"

// Summary of operation
// - Switching frequency 200 kHz to 1 MHz, from sync strap or frequency command.
// - Frequency is the 30 MHz reference divided by integer N, 30 to 150.
// - Non-exact requests pick the whole divisor giving the nearest frequency.
// - Sync strap decodes to sixteen frequencies; open pin selects 500 kHz.
// - Sync pin is external clock input, or clock output when internal.
// - Lost external clock sets the period fault flag and shuts down.
// - After a clock loss shutdown, re-enable runs on the internal oscillator.
// - External sync resumes only after reset strap or a select command.
// - First strap gives fault response, diode emulation, current limit.
// - Second strap gives loop gain and clock source; open means 400.
// - Strapped loop settings fix residual at 79 and integral at 100.
// - Loop gain and residual also settable by the loop command.
// - Limits: peak L, average 0.8L, warn 0.7L, undercurrent -0.8L, -L.
// - Straps are read before operation begins; the sync strap divisor is applied only when the division ends.
module scs_switch_clock (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic enable_i,
    input wire logic sync_i,
    input wire logic [3:0] sync_strap_i,
    input wire logic sync_strap_open_i,
    input wire logic [3:0] fault_limit_strap_i,
    input wire logic fault_limit_strap_open_i,
    input wire logic [3:0] loop_gain_strap_i,
    input wire logic loop_gain_strap_open_i,
    output logic sw_clk_o,
    output logic sync_o,
    output logic sync_oe_o,
    output logic run_o,
    output logic retry_mode_o,
    output logic diode_emul_o,
    output logic config_done_o
);

    // ==================================================
    // Pin synchronisers
    logic [16:0] pin_s1_ff;
    logic [16:0] pin_s2_ff;
    logic sync_s3_ff;
    wire [16:0] pin_raw = {enable_i, sync_i, sync_strap_open_i, fault_limit_strap_open_i,
                           loop_gain_strap_open_i, sync_strap_i, fault_limit_strap_i,
                           loop_gain_strap_i};
    wire en_s = pin_s2_ff[16];
    wire sync_s = pin_s2_ff[15];
    wire [3:0] sync_code = pin_s2_ff[14] ? `SCS_OPEN_SYNC : pin_s2_ff[11:8];
    wire [3:0] fault_limit_strap_code = pin_s2_ff[13] ? `SCS_OPEN_FAULT_LIMIT_STRAP : pin_s2_ff[7:4];
    wire [3:0] loop_gain_strap_code = pin_s2_ff[12] ? `SCS_OPEN_LOOP_GAIN_STRAP : pin_s2_ff[3:0];
    wire sync_rise = sync_s & ~sync_s3_ff;

    // Two flops on every pin, a third only for the sync edge
    always_ff @(posedge clk_i) begin
        pin_s1_ff <= pin_raw;
        pin_s2_ff <= pin_s1_ff;
        sync_s3_ff <= sync_s;
    end

    // ==================================================
    // Strap lookup tables
    function automatic logic [15:0] scs_sync_khz(input logic [3:0] c);
        case (c)
            4'h0: scs_sync_khz = 16'd250;
            4'h1: scs_sync_khz = 16'd300;
            4'h2: scs_sync_khz = 16'd353;
            4'h3: scs_sync_khz = 16'd400;
            4'h4: scs_sync_khz = 16'd455;
            4'h5: scs_sync_khz = 16'd500;
            4'h6: scs_sync_khz = 16'd545;
            4'h7: scs_sync_khz = 16'd600;
            4'h8: scs_sync_khz = 16'd652;
            4'h9: scs_sync_khz = 16'd698;
            4'ha: scs_sync_khz = 16'd750;
            4'hb: scs_sync_khz = 16'd811;
            4'hc: scs_sync_khz = 16'd857;
            4'hd: scs_sync_khz = 16'd909;
            4'he: scs_sync_khz = 16'd968;
            default: scs_sync_khz = 16'd1000;
        endcase
    endfunction : scs_sync_khz
    function automatic logic [15:0] scs_gain(input logic [2:0] c);
        case (c)
            3'h0: scs_gain = 16'd250;
            3'h1: scs_gain = 16'd300;
            3'h2: scs_gain = 16'd400;
            3'h3: scs_gain = 16'd500;
            3'h4: scs_gain = 16'd600;
            3'h5: scs_gain = 16'd700;
            3'h6: scs_gain = 16'd800;
            default: scs_gain = 16'd1000;
        endcase
    endfunction : scs_gain

    // ==================================================
    // State and configuration registers
    scs_pkg::scs_state_e st_ff;
    logic [2:0] settle_ff;
    logic [3:0] bit_ff;
    logic [15:0] rem_ff;
    logic [14:0] quo_ff;
    logic [15:0] req_khz_ff;
    logic pend_ff;
    logic [7:0] div_ff;
    logic ext_sel_ff;
    logic sout_en_ff;
    logic retry_ff;
    logic diode_ff;
    logic [1:0] ilim_ff;
    logic [15:0] gain_ff;
    logic [7:0] resid_ff;
    logic [7:0] integ_ff;
    logic fault_ff;
    logic shut_ff;
    logic [7:0] cnt_ff;
    logic [7:0] loss_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;

    // ==================================================
    // Bus decode
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr = req & wb_we_i;
    wire wr_ctrl = wr & (wb_adr_i == `SCS_OFF_CTRL) & wb_sel_i[0];
    wire wr_freq = wr & (wb_adr_i == `SCS_OFF_FREQ) & (&wb_sel_i[1:0]);
    wire wr_stat = wr & (wb_adr_i == `SCS_OFF_STAT) & wb_sel_i[0];
    wire wr_fcfg = wr & (wb_adr_i == `SCS_OFF_FCFG) & wb_sel_i[0];
    wire wr_loop = wr & (wb_adr_i == `SCS_OFF_LOOP);
    wire capt = (st_ff == scs_pkg::SCS_CAPT) && (settle_ff == 3'(`SCS_SETTLE_CYC - 1));
    wire done = (st_ff != scs_pkg::SCS_CAPT);

    // ==================================================
    // Divisor engine: long division then nearest pick
    localparam logic [14:0] REF_K = 15'(`SCS_REF_KHZ);
    wire [15:0] f_cl = (req_khz_ff < 16'(`SCS_FMIN_KHZ)) ? 16'(`SCS_FMIN_KHZ) :
                       (req_khz_ff > 16'(`SCS_FMAX_KHZ)) ? 16'(`SCS_FMAX_KHZ) : req_khz_ff;
    wire [15:0] trial = {rem_ff[14:0], REF_K[bit_ff]};
    wire trial_ok = trial >= f_cl;
    wire [7:0] n0 = quo_ff[7:0];
    wire [8:0] n1 = {1'b0, n0} + 9'h001;
    wire [24:0] err_hi = 25'(f_cl - rem_ff) * 25'(n0);
    wire [24:0] err_lo = 25'(rem_ff) * 25'(n1);
    wire [8:0] n_pick = (err_hi < err_lo) ? n1 : {1'b0, n0};
    wire [7:0] n_cl = (n_pick < 9'(`SCS_NMIN)) ? 8'(`SCS_NMIN) :
                      (n_pick > 9'(`SCS_NMAX)) ? 8'(`SCS_NMAX) : n_pick[7:0];

    // Divisor engine sequencing and strap capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= scs_pkg::SCS_CAPT;
            settle_ff <= 3'h0;
            bit_ff <= 4'h0;
            rem_ff <= 16'h0000;
            quo_ff <= 15'h0000;
            pend_ff <= 1'b0;
            div_ff <= `SCS_RST_DIV;
        end else begin
            case (st_ff)
                scs_pkg::SCS_CAPT: begin
                    settle_ff <= settle_ff + 3'h1;
                    if (capt) begin
                        st_ff <= scs_pkg::SCS_IDLE;
                        pend_ff <= 1'b1;
                    end
                end
                scs_pkg::SCS_IDLE: begin
                    if (pend_ff || wr_freq) begin
                        st_ff <= scs_pkg::SCS_DIV;
                        pend_ff <= 1'b0;
                        bit_ff <= 4'he;
                        rem_ff <= 16'h0000;
                        quo_ff <= 15'h0000;
                    end
                end
                scs_pkg::SCS_DIV: begin
                    rem_ff <= trial_ok ? trial - f_cl : trial;
                    quo_ff <= {quo_ff[13:0], trial_ok};
                    bit_ff <= bit_ff - 4'h1;
                    if (wr_freq) pend_ff <= 1'b1;
                    if (bit_ff == 4'h0) st_ff <= scs_pkg::SCS_PICK;
                end
                scs_pkg::SCS_PICK: begin
                    div_ff <= n_cl;
                    st_ff <= scs_pkg::SCS_IDLE;
                    if (wr_freq) pend_ff <= 1'b1;
                end
                default: st_ff <= scs_pkg::SCS_IDLE;
            endcase
        end
    end

    // Requested frequency: strap value first, command writes later
    always_ff @(posedge clk_i) begin
        if (rst_i) req_khz_ff <= `SCS_RST_KHZ;
        else if (capt) req_khz_ff <= scs_sync_khz(sync_code);
        else if (wr_freq) req_khz_ff <= wb_dat_i[15:0];
    end

    // ==================================================
    // Fault and loop configuration from straps, overridden by writes except the integral
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retry_ff <= 1'b0;
            diode_ff <= 1'b0;
            ilim_ff <= 2'h1;
            gain_ff <= `SCS_RST_GAIN;
            resid_ff <= `SCS_LOOP_RESID;
            integ_ff <= `SCS_LOOP_INTEG;
        end else if (capt) begin
            retry_ff <= fault_limit_strap_code[3];
            diode_ff <= fault_limit_strap_code[2];
            ilim_ff <= fault_limit_strap_code[1:0];
            gain_ff <= scs_gain(loop_gain_strap_code[2:0]);
            resid_ff <= `SCS_LOOP_RESID;
            integ_ff <= `SCS_LOOP_INTEG;
        end else begin
            if (wr_fcfg) begin
                retry_ff <= wb_dat_i[`SCS_FCFG_RETRY];
                diode_ff <= wb_dat_i[`SCS_FCFG_DIODE];
                ilim_ff <= wb_dat_i[3:2];
            end
            if (wr_loop && (&wb_sel_i[1:0])) gain_ff <= wb_dat_i[15:0];
            if (wr_loop && wb_sel_i[2]) resid_ff <= wb_dat_i[23:16];
        end
    end

    // Current limit thresholds derived from the step, strapped or written by FCFG
    wire [7:0] lim_l = 8'(8'd20 + 8'(ilim_ff) * 8'd10);
    wire [7:0] lim_avg = 8'((lim_l * 8'd4) / 8'd5);
    wire [7:0] lim_wrn = 8'((16'(lim_l) * 16'd7) / 16'd10);
    wire [7:0] lim_navg = 8'(8'h00 - lim_avg);
    wire [7:0] lim_nl = 8'(8'h00 - lim_l);

    // ==================================================
    // Clock source selection, loss detection and shutdown
    wire loss_hit = ext_sel_ff & run_o & (loss_ff == 8'(`SCS_LOSS_CYC - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sel_ff <= 1'b0;
            sout_en_ff <= 1'b0;
            fault_ff <= 1'b0;
            shut_ff <= 1'b0;
        end else begin
            if (capt) ext_sel_ff <= loop_gain_strap_code[3];
            else if (loss_hit) ext_sel_ff <= 1'b0;
            else if (wr_ctrl) ext_sel_ff <= wb_dat_i[`SCS_CTRL_EXT];
            if (wr_ctrl) sout_en_ff <= wb_dat_i[`SCS_CTRL_SOUT];
            if (loss_hit) fault_ff <= 1'b1;
            else if (wr_stat && wb_dat_i[`SCS_STAT_FAULT]) fault_ff <= 1'b0;
            if (loss_hit) shut_ff <= 1'b1;
            else if (!en_s) shut_ff <= 1'b0;
        end
    end

    // Cycles since the last sync edge while locked to it
    always_ff @(posedge clk_i) begin
        if (rst_i || sync_rise || !ext_sel_ff || !run_o) loss_ff <= 8'h00;
        else if (!loss_hit) loss_ff <= loss_ff + 8'h01;
    end

    // Internal period counter, restarts on each divisor wrap
    wire cnt_wrap = (cnt_ff >= div_ff - 8'h01);
    wire int_lvl = (cnt_ff < {1'b0, div_ff[7:1]});
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_wrap) cnt_ff <= 8'h00;
        else cnt_ff <= cnt_ff + 8'h01;
    end

    // ==================================================
    // Pin side outputs
    wire run_nxt = done & en_s & ~shut_ff & ~loss_hit;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_o <= 1'b0;
            sw_clk_o <= 1'b0;
            sync_o <= 1'b0;
            sync_oe_o <= 1'b0;
            retry_mode_o <= 1'b0;
            diode_emul_o <= 1'b0;
            config_done_o <= 1'b0;
        end else begin
            run_o <= run_nxt;
            sw_clk_o <= run_nxt & (ext_sel_ff ? sync_s : int_lvl);
            sync_o <= sout_en_ff & ~ext_sel_ff & int_lvl;
            sync_oe_o <= sout_en_ff & ~ext_sel_ff;
            retry_mode_o <= retry_ff;
            diode_emul_o <= diode_ff;
            config_done_o <= done;
        end
    end

    // ==================================================
    // Register read mux and single cycle acknowledge
    wire [31:0] stat_w = {27'h0, done, (st_ff != scs_pkg::SCS_IDLE) | pend_ff, run_o,
                          ext_sel_ff, fault_ff};
    logic [31:0] rmux;
    always_comb begin
        case (wb_adr_i)
            `SCS_OFF_CTRL: rmux = {30'h0, sout_en_ff, ext_sel_ff};
            `SCS_OFF_FREQ: rmux = {8'h00, div_ff, req_khz_ff};
            `SCS_OFF_STAT: rmux = stat_w;
            `SCS_OFF_FCFG: rmux = {28'h0, ilim_ff, diode_ff, retry_ff};
            `SCS_OFF_LOOP: rmux = {integ_ff, resid_ff, gain_ff};
            `SCS_OFF_LIM0: rmux = {lim_navg, lim_wrn, lim_avg, lim_l};
            `SCS_OFF_LIM1: rmux = {24'h0, lim_nl};
            `SCS_OFF_STRP: rmux = {20'h0, sync_code, loop_gain_strap_code, fault_limit_strap_code};
            default: rmux = 32'h0000_0000;
        endcase
    end

    // Ack follows a request by one cycle and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req;
            rdat_ff <= req ? rmux : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
endmodule : scs_switch_clock
`default_nettype wire

/* File: sim/scs_switch_clock_assertions.sv */
// Port-level checks for the switching clock block
`timescale 1ns/1ps
`default_nettype none
module scs_switch_clock_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic enable_i,
    input wire logic sw_clk_o,
    input wire logic run_o,
    input wire logic config_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] since_ff;
    logic req;
    assign req = wb_cyc_i && wb_stb_i;
    // Edges since reset release, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i)
            since_ff <= 8'h00;
        else if (since_ff != 8'hff)
            since_ff <= since_ff + 8'h01;
    end
    // ==========================================
    // Assertions
    ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    run_enable_a: assert property ($rose(run_o) |-> $past(enable_i, 2))
        else $error("run without enable");
    run_drop_a: assert property (!enable_i [*5] |-> !run_o)
        else $error("run while disabled");
    idle_low_a: assert property (!run_o && !$past(run_o) |-> !sw_clk_o)
        else $error("switching clock while stopped");
    done_time_a: assert property ($rose(config_done_o) |-> since_ff inside {[3:5]})
        else $error("strap capture at wrong time");
    done_hold_a: assert property (config_done_o |=> config_done_o)
        else $error("capture flag dropped");
    reset_quiet_a: assert property ($fell(rst_i) |-> !run_o && !config_done_o)
        else $error("outputs active after reset");
    // Main scenarios
    read_c: cover property (req && !wb_ack_o ##1 wb_ack_o);
    run_c: cover property ($rose(run_o));
    stop_c: cover property ($fell(run_o) && enable_i);
endmodule : scs_switch_clock_chk
bind scs_switch_clock scs_switch_clock_chk scs_switch_clock_chk_i (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .enable_i, .sw_clk_o, .run_o, .config_done_o);
`default_nettype wire

/* File: sim/scs_sync_source.sv */
// External sync clock source model
`timescale 1ns/1ps
`default_nettype none
module scs_sync_source (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [7:0] half_i,
    output logic sync_o
);
    logic [7:0] cnt_ff;
    // Square wave of half_i cycles a phase, stands low when stopped
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cnt_ff <= 8'h00;
            sync_o <= 1'b0;
        end else if (cnt_ff + 8'h01 >= half_i) begin
            cnt_ff <= 8'h00;
            sync_o <= !sync_o;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule : scs_sync_source
`default_nettype wire

/* File: sim/test_scs_switch_clock.sv */
// Self-checking bench for the switching clock block
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"
module test_scs_switch_clock;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, en = 0, ext_run = 0;
    logic so = 0, o0 = 0, o1 = 0;
    logic [7:0] adr = 8'h00, half = 8'h19;
    logic [3:0] sc = 4'h0, c0 = 4'h0, c1 = 4'h0, ks, k0, k1;
    logic [31:0] wdat = 32'h0, q, dat;
    logic ack, swc, sync_d, sync_oe, run, retry, diode, done, ext_sync, pin;
    int error_cnt = 0, samples_checked = 0, f, n, l, p, h;
    int fr[16] = '{250, 300, 353, 400, 455, 500, 545, 600, 652, 698, 750, 811, 857, 909, 968, 1000};
    int gn[8] = '{250, 300, 400, 500, 600, 700, 800, 1000};
    int fc[5] = '{595, 200, 1000, 150, 2000};
    always #50 clk_i = ~clk_i;
    assign pin = sync_oe ? sync_d : ext_sync;
    // Only one device sits on the management bus, so its address cannot clash
    scs_switch_clock scs_switch_clock_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat), .wb_ack_o(ack), .enable_i(en), .sync_i(pin), .sync_strap_i(sc),
        .sync_strap_open_i(so), .fault_limit_strap_i(c0), .fault_limit_strap_open_i(o0),
        .loop_gain_strap_i(c1), .loop_gain_strap_open_i(o1), .sw_clk_o(swc), .sync_o(sync_d),
        .sync_oe_o(sync_oe), .run_o(run), .retry_mode_o(retry), .diode_emul_o(diode),
        .config_done_o(done));
    scs_sync_source scs_sync_source_i (.clk_i(clk_i), .run_i(ext_run), .half_i(half),
        .sync_o(ext_sync));
    // ==========================================
    // Helpers
    task chk_w(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t word %h expected %h", $time, g, e);
        end
    endtask : chk_w
    task chk_b(input logic g, input logic e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t level %b expected %b", $time, g, e);
        end
    endtask : chk_b
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 40);
        q = dat;
        chk_b(t < 40, 1'b1);
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb
    task wait_idle;
        for (int t = 0; t < 60; t++) begin
            wb(0, `SCS_OFF_STAT, 0);
            if (q[3] === 1'b0) break;
        end
    endtask : wait_idle
    function automatic int exp_div(int r);
        int k;
        if (r < 200) r = 200;
        if (r > 1000) r = 1000;
        k = 30000 / r;
        if (r - 30000.0 / (k + 1) < 30000.0 / k - r) k = k + 1;
        return (k < 30) ? 30 : (k > 150) ? 150 : k;
    endfunction : exp_div
    task wrap_up;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        wrap_up();
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h9f2fd574));
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            rst_i <= 1;
            sc <= (i == 1) ? 4'h0 : 4'($urandom);
            c0 <= (i == 1) ? 4'hf : 4'($urandom);
            c1 <= (i == 1) ? 4'hf : 4'($urandom);
            so <= (i == 3);
            o0 <= (i == 3);
            o1 <= (i == 3);
            repeat (12) @(posedge clk_i);
            rst_i <= 0;
            repeat (6) @(posedge clk_i);
            chk_b(done, 1'b1);
            wait_idle();
            ks = so ? `SCS_OPEN_SYNC : sc;
            k0 = o0 ? `SCS_OPEN_FAULT_LIMIT_STRAP : c0;
            k1 = o1 ? `SCS_OPEN_LOOP_GAIN_STRAP : c1;
            l = 20 + 10 * k0[1:0];
            wb(0, `SCS_OFF_STRP, 0);
            chk_w(q & 32'hfff, {20'h0, ks, k1, k0});
            wb(0, `SCS_OFF_CTRL, 0);
            chk_w(q & 32'h3, {31'h0, k1[3]});
            wb(0, `SCS_OFF_FCFG, 0);
            chk_w(q & 32'hf, {28'h0, k0[1:0], k0[2], k0[3]});
            chk_b(retry, k0[3]);
            chk_b(diode, k0[2]);
            wb(0, `SCS_OFF_LOOP, 0);
            chk_w(q, {8'd100, 8'd79, 16'(gn[k1[2:0]])});
            wb(0, `SCS_OFF_LIM0, 0);
            chk_w(q, {8'(-l * 8 / 10), 8'(l * 7 / 10), 8'(l * 8 / 10), 8'(l)});
            wb(0, `SCS_OFF_LIM1, 0);
            chk_w(q & 32'hff, {24'h0, 8'(-l)});
            wb(0, `SCS_OFF_FREQ, 0);
            chk_w(q & 32'hffffff, {8'(exp_div(fr[ks])), 16'(fr[ks])});
        end
        // Frequency requests, corners then random
        for (int j = 0; j < 8; j++) begin
            f = (j < 5) ? fc[j] : 200 + $urandom_range(800);
            wb(1, `SCS_OFF_FREQ, f);
            wait_idle();
            wb(0, `SCS_OFF_FREQ, 0);
            chk_w(q[23:16], exp_div(f));
        end
        n = exp_div(f);
        en <= 1;
        repeat (10) @(posedge clk_i);
        do @(posedge clk_i); while (swc !== 1'b0);
        do @(posedge clk_i); while (swc !== 1'b1);
        p = 0;
        while (swc === 1'b1 && p < 400) begin
            @(posedge clk_i);
            p++;
        end
        h = p;
        while (swc === 1'b0 && p < 400) begin
            @(posedge clk_i);
            p++;
        end
        chk_w(p, n);
        chk_w(h, n / 2);
        wb(1, `SCS_OFF_CTRL, 2);
        repeat (3) @(posedge clk_i);
        chk_b(sync_oe, 1'b1);
        chk_b(sync_d, swc);
        wb(1, `SCS_OFF_LOOP, 32'h0033_02bc);
        wb(0, `SCS_OFF_LOOP, 0);
        chk_w(q, 32'h6433_02bc);
        wb(1, `SCS_OFF_FCFG, 1);
        repeat (2) @(posedge clk_i);
        chk_b(retry, 1'b1);
        chk_b(diode, 1'b0);
        // External clock near the programmed rate, then lost
        half <= 8'(n / 2);
        ext_run <= 1;
        wb(1, `SCS_OFF_CTRL, 1);
        repeat (20) @(posedge clk_i);
        wb(0, `SCS_OFF_STAT, 0);
        chk_w(q & 32'h7, 32'h6);
        ext_run <= 0;
        repeat (250) @(posedge clk_i);
        wb(0, `SCS_OFF_STAT, 0);
        chk_w(q & 32'h7, 32'h1);
        chk_b(run, 1'b0);
        ext_run <= 1;
        en <= 0;
        repeat (6) @(posedge clk_i);
        en <= 1;
        repeat (10) @(posedge clk_i);
        wb(0, `SCS_OFF_STAT, 0);
        chk_w(q & 32'h7, 32'h5);
        wb(1, `SCS_OFF_STAT, 1);
        wb(0, `SCS_OFF_STAT, 0);
        chk_w(q & 32'h1, 32'h0);
        wb(1, `SCS_OFF_CTRL, 1);
        repeat (20) @(posedge clk_i);
        wb(0, `SCS_OFF_STAT, 0);
        chk_w(q & 32'h7, 32'h6);
        wb(0, 8'h40, 0);
        chk_w(q, 32'h0);
        wrap_up();
    end
endmodule : test_scs_switch_clock
`default_nettype wire
